//--- hw/clock_gen_pkg.sv
// constants, types and register layout of the clock generator status block
// assumes one bus clock and a simple strobe register port
//
// How it works
// - two-bit mode state: 00 self, 01 internal fll, 10 bypass, 11 external fll
// - reference state bit: 0 external clock, 1 crystal selected
// - sticky loss-of-lock flag set on unexpected unlock, held until cleared
// - lock bit follows lock, forced low in off, self and bypass modes
// - sticky loss-of-clock flag set on clock loss outside the off state, held until cleared
// - external reference stable bit follows the stable-and-fast-enough input
// - interrupt flag set while a request is pending, cleared by reset
// - flag clears only after status read with flag set, then write one
// - a new interrupt during the clear sequence restarts the sequence
// - writing zero to the interrupt flag leaves it set but cancels the armed clear sequence
// - oscillator stable after two in-tolerance samples and a non-static clock
// - leaving off with select x1 waits for oscillator stable
// - self mode starts oscillator monitoring only once stable
// - entering off clears the oscillator stable bit
// - loss of lock raises interrupt if its reset enable is 0, else reset
// - loss of clock raises interrupt if its reset enable is 0, else reset
package clock_gen_pkg;

  localparam logic [3:0] mode_status_addr = 4'h0;
  localparam logic [3:0] osc_status_addr  = 4'h1;
  localparam logic [3:0] irq_mask_addr    = 4'h2;
  localparam logic [3:0] event_status_addr = 4'h3;

  localparam int mode_pos   = 6;
  localparam int ref_pos    = 5;
  localparam int lol_pos    = 4;
  localparam int lock_pos   = 3;
  localparam int loc_pos    = 2;
  localparam int ext_ref_stable_pos   = 1;
  localparam int irqf_pos   = 0;
  localparam int osc_pos    = 0;

  localparam logic [7:0] mask_reset  = 8'h00;
  localparam logic [1:0] samples_needed = 2'h2;

  typedef enum logic [1:0] {
    mode_self     = 2'b00,
    mode_fll_int  = 2'b01,
    mode_bypass   = 2'b10,
    mode_fll_ext  = 2'b11
  } clock_mode_t;

  // gray along off -> wait -> run
  typedef enum logic [1:0] {
    st_off  = 2'b00,
    st_wait = 2'b01,
    st_run  = 2'b11
  } run_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // pulse mask layout of the event register
  localparam int ev_lol = 0;
  localparam int ev_loc = 1;
  localparam int ev_irq = 2;

endpackage : clock_gen_pkg

//--- hw/clock_gen_status_flags.sv
// status flags of the clock generator: mode, lock, loss flags, stability, irq flag
// assumes the analog fll, oscillator and reference monitor drive the raw inputs
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module clock_gen_status_flags
  import clock_gen_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // register port
  input  wire clock_gen_pkg::reg_req_t req,
  output logic [7:0]                 rdata,
  // control from the configuration side
  input  wire logic [1:0]            clock_mode_select,
  input  wire logic                  reference_select,
  input  wire logic                  lock_loss_reset_enable,
  input  wire logic                  clock_loss_reset_enable,
  input  wire logic                  off_request,
  // monitor inputs
  input  wire logic                  fll_locked,
  input  wire logic                  clock_lost,
  input  wire logic                  ext_ref_ok,
  input  wire logic                  count_in_tolerance,
  input  wire logic                  count_sample,
  input  wire logic                  osc_toggling,
  // outputs
  output logic                       reset_request,
  output logic                       irq,
  output logic                       osc_monitor_enable
);
  import clock_gen_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // mode state machine and synchronised select

  logic [1:0]  sel_meta_q;
  logic [1:0]  sel_sync_q;
  run_state_t  run_q;
  clock_mode_t clock_mode_state_q;
  logic        reference_select_state_q;
  logic        osc_stable_flag_q;
  logic [1:0]  good_count_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
    end else if (clk_en) begin
      sel_meta_q <= clock_mode_select;
      sel_sync_q <= sel_meta_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= st_run;
    end else if (clk_en) begin
      case (run_q)
        st_run: begin
          if (off_request) begin
            run_q <= st_off;
          end
        end
        st_off: begin
          if (!off_request) begin
            run_q <= sel_sync_q[0] ? st_wait : st_run;
          end
        end
        st_wait: begin
          if (off_request) begin
            run_q <= st_off;
          end else if (osc_stable_flag_q) begin
            run_q <= st_run;
          end
        end
        default: begin
          run_q <= st_run;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_mode_state_q <= mode_self;
    end else if (clk_en) begin
      if (run_q == st_run) begin
        clock_mode_state_q <= clock_mode_t'(sel_sync_q);
      end else begin
        clock_mode_state_q <= mode_self;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reference_select_state_q <= 1'b0;
    end else if (clk_en) begin
      reference_select_state_q <= reference_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator stability

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      good_count_q      <= 2'h0;
      osc_stable_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (run_q == st_off) begin
        good_count_q      <= 2'h0;
        osc_stable_flag_q <= 1'b0;
      end else if (!osc_toggling) begin
        good_count_q      <= 2'h0;
        osc_stable_flag_q <= 1'b0;
      end else if (count_sample) begin
        if (!count_in_tolerance) begin
          good_count_q      <= 2'h0;
          osc_stable_flag_q <= 1'b0;
        end else if (good_count_q != samples_needed) begin
          good_count_q      <= good_count_q + 2'h1;
          osc_stable_flag_q <= (good_count_q + 2'h1) == samples_needed;
        end
      end
    end
  end

  always_comb begin
    osc_monitor_enable = (run_q != st_off) && (clock_mode_state_q == mode_self) && osc_stable_flag_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock and loss flags

  logic lock_q;
  logic lock_prev_q;
  logic loss_of_lock_flag_q;
  logic loss_of_clock_flag_q;
  logic ext_ref_stable_q;
  logic fll_engaged;
  logic lol_event;
  logic loc_event;
  logic status_read;
  logic status_write;

  assign fll_engaged = (run_q == st_run) && clock_mode_state_q[0];
  assign lol_event   = lock_prev_q && !fll_locked && fll_engaged;
  assign loc_event   = clock_lost && (run_q != st_off);
  assign status_read  = req.rd && (req.addr == mode_status_addr);
  assign status_write = req.wr && (req.addr == mode_status_addr);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_q      <= 1'b0;
      lock_prev_q <= 1'b0;
    end else if (clk_en) begin
      lock_q      <= fll_engaged && fll_locked;
      lock_prev_q <= fll_engaged && fll_locked;
    end
  end

  // sticky loss of lock, set beats write-one clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loss_of_lock_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (lol_event) begin
        loss_of_lock_flag_q <= 1'b1;
      end else if (status_write && req.wdata[lol_pos]) begin
        loss_of_lock_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loss_of_clock_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (loc_event) begin
        loss_of_clock_flag_q <= 1'b1;
      end else if (status_write && req.wdata[loc_pos]) begin
        loss_of_clock_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_ref_stable_q <= 1'b0;
    end else if (clk_en) begin
      ext_ref_stable_q <= ext_ref_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt flag and reset request

  logic clock_gen_irq_flag_q;
  logic clear_armed_q;
  logic irq_event;
  logic rst_event;

  assign irq_event = (lol_event && !lock_loss_reset_enable) || (loc_event && !clock_loss_reset_enable);
  assign rst_event = (lol_event && lock_loss_reset_enable) || (loc_event && clock_loss_reset_enable);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_request <= 1'b0;
    end else if (clk_en) begin
      reset_request <= rst_event;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clear_armed_q <= 1'b0;
    end else if (clk_en) begin
      if (irq_event) begin
        clear_armed_q <= 1'b0;
      end else if (status_read && clock_gen_irq_flag_q) begin
        clear_armed_q <= 1'b1;
      end else if (status_write) begin
        clear_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_gen_irq_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (irq_event) begin
        clock_gen_irq_flag_q <= 1'b1;
      end else if (status_write && req.wdata[irqf_pos] && clear_armed_q) begin
        clock_gen_irq_flag_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt line

  logic [7:0] irq_mask_q;
  logic [7:0] event_status_q;
  logic [7:0] event_set;

  always_comb begin
    event_set         = 8'h00;
    event_set[ev_lol] = lol_event;
    event_set[ev_loc] = loc_event;
    event_set[ev_irq] = irq_event;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask_q <= mask_reset;
    end else if (clk_en && req.wr && req.addr == irq_mask_addr) begin
      irq_mask_q <= req.wdata;
    end
  end

  // read clears, but a same-cycle event survives
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      event_status_q <= 8'h00;
    end else if (clk_en) begin
      if (req.rd && req.addr == event_status_addr) begin
        event_status_q <= event_set;
      end else begin
        event_status_q <= event_status_q | event_set;
      end
    end
  end

  assign irq = |(event_status_q & irq_mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] mode_word;

  always_comb begin
    mode_word                          = 8'h00;
    mode_word[mode_pos+1:mode_pos]     = clock_mode_state_q;
    mode_word[ref_pos]                 = reference_select_state_q;
    mode_word[lol_pos]                 = loss_of_lock_flag_q;
    // lock_q lags a mode change by a cycle, so gate it with the live engagement
    mode_word[lock_pos]                = lock_q && fll_engaged;
    mode_word[loc_pos]                 = loss_of_clock_flag_q;
    mode_word[ext_ref_stable_pos]                = ext_ref_stable_q;
    mode_word[irqf_pos]                = clock_gen_irq_flag_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      if (req.rd) begin
        case (req.addr)
          mode_status_addr:  rdata <= mode_word;
          osc_status_addr:   rdata <= {7'h00, osc_stable_flag_q};
          irq_mask_addr:     rdata <= irq_mask_q;
          event_status_addr: rdata <= event_status_q;
          default:           rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

endmodule : clock_gen_status_flags

//--- testbench/clock_gen_status_flags_checker.sv
// assertions on the ports of the clock generator status block
// assumes clk_en held high and one-cycle clock_lost pulses
`timescale 1ns/1ps
module clock_gen_status_flags_checker
  import clock_gen_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // watched ports
  input wire clock_gen_pkg::reg_req_t req,
  input wire logic [7:0]              rdata,
  input wire logic                    reference_select,
  input wire logic                    lock_loss_reset_enable,
  input wire logic                    clock_loss_reset_enable,
  input wire logic                    off_request,
  input wire logic                    clock_lost,
  input wire logic                    ext_ref_ok,
  input wire logic                    reset_request,
  input wire logic                    irq,
  input wire logic                    osc_monitor_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_idle_read_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside a read");
  a_unmapped_read_zero: assert property ($past(req.rd) && $past(req.addr) > event_status_addr
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  a_ref_state_shown: assert property ($past(req.rd) && $past(req.addr) == mode_status_addr
    |-> rdata[ref_pos] == $past(reference_select, 2)) else $error("reference state wrong");
  a_lock_low_unengaged: assert property ($past(req.rd) && $past(req.addr) == mode_status_addr
    && !rdata[mode_pos] |-> !rdata[lock_pos]) else $error("lock shown outside engaged mode");
  a_ext_ref_shown: assert property ($past(req.rd) && $past(req.addr) == mode_status_addr
    && $past(ext_ref_ok, 2) == $past(ext_ref_ok) |-> rdata[ext_ref_stable_pos] == $past(ext_ref_ok))
    else $error("external reference state wrong");
  a_reset_req_cause: assert property (reset_request
    |-> $past(lock_loss_reset_enable) || $past(clock_loss_reset_enable)) else $error("reset request uncaused");
  a_loc_reset_req: assert property ($past(clock_lost) && $past(clock_loss_reset_enable)
    && !$past(off_request, 2) |-> reset_request) else $error("clock loss gave no reset request");
  a_off_monitor_low: assert property ($past(off_request) |-> !osc_monitor_enable)
    else $error("monitor enabled in off state");
  c_reset_req: cover property (reset_request);
  c_irq: cover property ($rose(irq));
  c_monitor: cover property ($rose(osc_monitor_enable));
endmodule : clock_gen_status_flags_checker
////////////////////////////////////////
bind clock_gen_status_flags clock_gen_status_flags_checker clock_gen_status_flags_checker_inst (
  .clk, .reset, .req, .rdata, .reference_select, .lock_loss_reset_enable, .clock_loss_reset_enable,
  .off_request, .clock_lost, .ext_ref_ok, .reset_request, .irq, .osc_monitor_enable);

//--- testbench/clock_gen_status_flags_tb.sv
// register-level bench of the clock generator status block
// assumes the package register map and a three-cycle mode lag
`timescale 1ns/1ps
module clock_gen_status_flags_tb;
  import clock_gen_pkg::*;
  logic       clk, reset, clk_en, reference_select, lock_loss_reset_enable, clock_loss_reset_enable;
  logic       off_request, fll_locked, clock_lost, ext_ref_ok, count_in_tolerance, count_sample;
  logic       osc_toggling, reset_request, irq, osc_monitor_enable;
  logic [1:0] clock_mode_select, prev;
  logic [7:0] rdata, d;
  reg_req_t   req;
  int         failures, compares, cycles;
  clock_gen_status_flags clock_gen_status_flags_inst (.clk, .reset, .clk_en, .req, .rdata,
    .clock_mode_select, .reference_select, .lock_loss_reset_enable, .clock_loss_reset_enable,
    .off_request, .fll_locked, .clock_lost, .ext_ref_ok, .count_in_tolerance, .count_sample,
    .osc_toggling, .reset_request, .irq, .osc_monitor_enable);
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a hang costs one mismatch, the run needs well under this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      results();
    end
  end
  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
    chk(d & m, e);
  endtask : rm
  task automatic smp(input logic t);
    @(posedge clk) begin
      count_sample <= 1'b1;
      count_in_tolerance <= t;
    end
    @(posedge clk) count_sample <= 1'b0;
  endtask : smp
  task automatic lost();
    @(posedge clk) clock_lost <= 1'b1;
    @(posedge clk) clock_lost <= 1'b0;
  endtask : lost
  ////////////////////////////////////////
  initial begin
    failures = 0; compares = 0; cycles = 0; reset = 1'b1; clk_en = 1'b1; req = '0;
    clock_mode_select = 2'b00; reference_select = 1'b1; lock_loss_reset_enable = 1'b0;
    clock_loss_reset_enable = 1'b0; off_request = 1'b0; fll_locked = 1'b1; clock_lost = 1'b0;
    ext_ref_ok = 1'b1; count_in_tolerance = 1'b0; count_sample = 1'b0; osc_toggling = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rm(irq_mask_addr, 8'hff, mask_reset);
    wr(4'hf, 8'hff);
    rm(4'hf, 8'hff, 8'h00);
    rm(osc_status_addr, 8'hff, 8'h00);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk) begin
        reference_select <= v[0];
        ext_ref_ok <= v[0];
      end
      repeat (4) @(posedge clk);
      rm(mode_status_addr, 8'hff, {2'b00, v[0], 3'b000, v[0], 1'b0});
    end
    smp(1'b1); smp(1'b0); smp(1'b1);
    rm(osc_status_addr, 8'h01, 8'h00);
    smp(1'b1);
    rm(osc_status_addr, 8'h01, 8'h01);
    chk({7'h00, osc_monitor_enable}, 8'h01);
    @(posedge clk) begin
      off_request <= 1'b1;
      clock_mode_select <= mode_fll_int;
    end
    repeat (6) @(posedge clk);
    rm(osc_status_addr, 8'h01, 8'h00);
    @(posedge clk) off_request <= 1'b0;
    repeat (6) @(posedge clk);
    rm(mode_status_addr, 8'hc8, 8'h00);
    smp(1'b1); smp(1'b1);
    repeat (6) @(posedge clk);
    rm(mode_status_addr, 8'hc8, 8'h48);
    prev = mode_fll_int;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) clock_mode_select <= m[1:0];
      rm(mode_status_addr, 8'hc0, {prev, 6'h00});
      repeat (6) @(posedge clk);
      rm(mode_status_addr, 8'hc8, {m[1:0], 2'b00, m[0], 3'b000});
      prev = m[1:0];
    end
    wr(irq_mask_addr, 8'hff);
    @(posedge clk) fll_locked <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rm(mode_status_addr, 8'h1d, 8'h11);
    wr(mode_status_addr, 8'h00);
    wr(mode_status_addr, 8'h01);
    rm(mode_status_addr, 8'h11, 8'h11);
    wr(mode_status_addr, 8'h01);
    rm(mode_status_addr, 8'h11, 8'h10);
    lost();
    rm(mode_status_addr, 8'h05, 8'h05);
    lost();
    wr(mode_status_addr, 8'h01);
    rm(mode_status_addr, 8'h01, 8'h01);
    wr(mode_status_addr, 8'h15);
    rm(mode_status_addr, 8'h15, 8'h00);
    rm(event_status_addr, 8'h03, 8'h03);
    rm(event_status_addr, 8'h07, 8'h00);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk) clock_loss_reset_enable <= 1'b1;
    lost();
    #1 chk({7'h00, reset_request}, 8'h01);
    rm(mode_status_addr, 8'h05, 8'h04);
    @(posedge clk) begin
      fll_locked <= 1'b1;
      lock_loss_reset_enable <= 1'b1;
    end
    repeat (3) @(posedge clk);
    @(posedge clk) fll_locked <= 1'b0;
    @(posedge clk);
    #1 chk({7'h00, reset_request}, 8'h01);
    rm(mode_status_addr, 8'h11, 8'h10);
    wr(irq_mask_addr, 8'h00);
    @(posedge clk) clock_loss_reset_enable <= 1'b0;
    lost();
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rm(event_status_addr, 8'h02, 8'h02);
    // a loss while the enable is low must leave no trace
    @(posedge clk) clk_en <= 1'b0;
    lost();
    @(posedge clk) clk_en <= 1'b1;
    rm(event_status_addr, 8'h07, 8'h00);
    rm(osc_status_addr, 8'h01, 8'h01);
    @(posedge clk) osc_toggling <= 1'b0;
    rm(osc_status_addr, 8'h01, 8'h00);
    results();
  end
endmodule : clock_gen_status_flags_tb
